// ==== include/pec_params.svh ====
/*
 * Register addresses, field positions, reset values and widths of the event counter unit.
 * Assumes the core delivers register accesses as an address plus 64-bit data.
 */
`ifndef PEC_PARAMS_SVH
`define PEC_PARAMS_SVH

`define PEC_NUM_GP 2
`define PEC_NUM_FIX 3
`define PEC_CTR_WIDTH 48
`define PEC_ADDR_GP_CTR 12'h0c1
`define PEC_ADDR_EVTSEL 12'h186
`define PEC_ADDR_FIX_CTR 12'h309
`define PEC_ADDR_FIX_CTRL 12'h38d
`define PEC_ADDR_ALIAS 12'h4c1
`define PEC_ADDR_GLB_STATUS 12'h38e
`define PEC_ADDR_GLB_ENABLE 12'h38f
`define PEC_ADDR_GLB_OVF_CLR 12'h390
`define PEC_ADDR_CAPS 12'h345
`define PEC_GP_COUNT_LSB 8
`define PEC_GP_WIDTH_LSB 16
`define PEC_FULL_WIDTH_WRITE_CAPABLE_BIT 13
`define PEC_SEL_EVENT_LSB 0
`define PEC_SEL_UMASK_LSB 8
`define PEC_SEL_USR_BIT 16
`define PEC_SEL_OS_BIT 17
`define PEC_SEL_ANY_BIT 21
`define PEC_SEL_EN_BIT 22
`define PEC_FIX_OS_BIT 0
`define PEC_FIX_USR_BIT 1
`define PEC_FIX_ANY_BIT 2
`define PEC_FIX_BLOCK 4
`define PEC_GLB_FIX_LSB 32
`define PEC_EVT_UNAVAIL_RESET 7'h00
`define PEC_EV_CYC 8'h3c
`define PEC_EV_INST 8'hc0
`define PEC_EV_LLC 8'h2e
`define PEC_EV_BR 8'hc4
`define PEC_EV_BRMISS 8'hc5
`define PEC_UM_ZERO 8'h00
`define PEC_UM_REF 8'h01
`define PEC_UM_LLC_REF 8'h4f
`define PEC_UM_LLC_MISS 8'h41

`endif

// ==== include/pec_pkg.sv ====
/*
 * Types shared by the event counter unit.
 * Assumes pec_params.svh is available on the include path.
 */
package pec_pkg;
	// One core's worth of raw event pulses for one thread.
	typedef struct packed {
		logic core_cycle;
		logic ref_cycle;
		logic inst_retired;
		logic llc_ref;
		logic llc_miss;
		logic br_retired;
		logic br_miss;
	} pec_events_t;

	// Core state that gates the cycle events and, on VM exit, the retired-instruction event.
	typedef struct packed {
		logic halted;
		logic sleep_not_c0;
		logic stop_clock_input;
		logic thermal_throttle;
		logic freq_switching;
		logic vm_exit;
	} pec_core_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [63:0] data;
	} pec_req_t;

	typedef enum logic [1:0] {
		PEC_SRC_NONE = 2'b00,
		PEC_SRC_GP = 2'b01,
		PEC_SRC_FIX = 2'b10
	} pec_src_t;
endpackage

// ==== logic/pec_event_match.sv ====
/*
 * Selects one event bit from the predefined event set by event and unit mask codes.
 * Assumes the event vectors are already gated for core state.
 */
`include "pec_params.svh"

module pec_event_match (
	// Selector
	input wire logic [7:0] event_code,
	input wire logic [7:0] unit_mask,
	// Events
	input wire pec_pkg::pec_events_t events,
	// Result
	output logic hit
);
	always_comb begin
		hit = 1'b0;
		case (event_code)
			`PEC_EV_CYC: begin
				if (unit_mask == `PEC_UM_ZERO) hit = events.core_cycle;
				else if (unit_mask == `PEC_UM_REF) hit = events.ref_cycle;
			end
			`PEC_EV_INST: hit = (unit_mask == `PEC_UM_ZERO) && events.inst_retired;
			`PEC_EV_LLC: begin
				if (unit_mask == `PEC_UM_LLC_REF) hit = events.llc_ref;
				else if (unit_mask == `PEC_UM_LLC_MISS) hit = events.llc_miss;
			end
			`PEC_EV_BR: hit = (unit_mask == `PEC_UM_ZERO) && events.br_retired;
			`PEC_EV_BRMISS: hit = (unit_mask == `PEC_UM_ZERO) && events.br_miss;
			default: hit = 1'b0;
		endcase
	end
endmodule

// ==== logic/pec_unit.sv ====
/*
 * Performance event counter unit: general and fixed counters, their controls and global
 * enable, status and overflow clear, reached through register read and write requests.
 * Assumes requests, events and core state are synchronous to clk; thread 0 programs it.
 */
// Behaviour
// - Enumeration reports general counter count at 15:8 and width at 23:16.
// - General counters from 0C1H, their event selects from 186H.
// - Event select bit 21 counts qualified events of all sibling threads.
// - Fixed counters from 309H, each governed by a 4-bit control block.
// - Fixed control any-thread bit at 2 plus four times the index.
// - Global enable, status and clear have one bit per counter.
// - Normal counter write loads low 32 bits sign-extended.
// - Capabilities bit 13 advertises full-width counter writes.
// - Full-width aliases start at 4C1H, one per general counter.
// - Alias write loads both words, sign-extended from counter width.
// - Event 3CH mask 00H counts core cycles across frequency changes.
// - Core cycles stop when halted, asleep, stop-clocked, throttled or switching.
// - Event C0H counts each retired instruction once at its last micro-op.
// - Retired instructions not counted on VM exit, counted in interrupts.
// - Event 3CH mask 01H counts reference clock cycles while core runs.
// - Event 2EH mask 4FH counts last-level cache references.
// - Event 2EH mask 41H counts last-level cache misses.
// - Event C4H counts retired branch instructions.
// - Event C5H counts retired mispredicted branches.
// - Availability vector bits 0 to 6 mark unavailable predefined events.
// - Fixed block bit 0 counts at ring 0, bit 1 above ring 0.
// - A counter counts only with global and privilege enables true.
// - Status bits 0,1 for general, 32 to 34 for fixed overflows.
`include "pec_params.svh"

module pec_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register access
	input wire pec_pkg::pec_req_t req,
	output logic [63:0] rd_data,
	output logic rd_valid,
	// Enumeration
	output logic [31:0] enum_counters,
	output logic [31:0] enum_unavailable,
	// Events from this thread and the sibling thread
	input wire pec_pkg::pec_events_t events_self,
	input wire pec_pkg::pec_events_t events_sibling,
	input wire logic [1:0] priv_self,
	input wire logic [1:0] priv_sibling,
	input wire pec_pkg::pec_core_state_t core_state,
	input wire logic ref_clock_tick
);
	localparam int NG = `PEC_NUM_GP;
	localparam int NF = `PEC_NUM_FIX;
	localparam int W = `PEC_CTR_WIDTH;

	logic [W-1:0] gp_reg [NG];
	logic [W-1:0] gp_next [NG];
	logic [63:0] sel_reg [NG];
	logic [63:0] sel_next [NG];
	logic [W-1:0] fix_reg [NF];
	logic [W-1:0] fix_next [NF];
	logic [4*NF-1:0] fctl_reg;
	logic [4*NF-1:0] fctl_next;
	logic [NG-1:0] gen_gp_reg;
	logic [NG-1:0] gen_gp_next;
	logic [NF-1:0] gen_fix_reg;
	logic [NF-1:0] gen_fix_next;
	logic [NG-1:0] ovf_gp_reg;
	logic [NG-1:0] ovf_gp_next;
	logic [NF-1:0] ovf_fix_reg;
	logic [NF-1:0] ovf_fix_next;
	logic [63:0] rd_data_reg;
	logic [63:0] rd_data_next;
	logic rd_valid_reg;
	logic rd_valid_next;

	pec_pkg::pec_events_t ev_self_q;
	pec_pkg::pec_events_t ev_sib_q;
	logic core_running;
	logic [1:0] gp_inc [NG];
	logic [1:0] fix_inc [NF];
	logic [W:0] gp_sum [NG];
	logic [W:0] fix_sum [NF];

	// Core and reference cycles only advance while the core clock really runs.
	assign core_running = !(core_state.halted || core_state.sleep_not_c0
		|| core_state.stop_clock_input || core_state.thermal_throttle
		|| core_state.freq_switching);

	always_comb begin
		ev_self_q = events_self;
		ev_self_q.core_cycle = events_self.core_cycle && core_running;
		ev_self_q.ref_cycle = ref_clock_tick && core_running;
		ev_self_q.inst_retired = events_self.inst_retired && !core_state.vm_exit;
		ev_sib_q = events_sibling;
		ev_sib_q.core_cycle = events_sibling.core_cycle && core_running;
		ev_sib_q.ref_cycle = ref_clock_tick && core_running;
		ev_sib_q.inst_retired = events_sibling.inst_retired && !core_state.vm_exit;
	end

	// General counters: event match per thread, privilege qualified per thread.
	genvar g;
	generate
		for (g = 0; g < NG; g++) begin : gp_lane
			logic hit_self;
			logic hit_sib;
			logic ok_self;
			logic ok_sib;
			pec_event_match match_self (
				.event_code(sel_reg[g][`PEC_SEL_EVENT_LSB +: 8]),
				.unit_mask(sel_reg[g][`PEC_SEL_UMASK_LSB +: 8]),
				.events(ev_self_q),
				.hit(hit_self)
			);
			pec_event_match match_sib (
				.event_code(sel_reg[g][`PEC_SEL_EVENT_LSB +: 8]),
				.unit_mask(sel_reg[g][`PEC_SEL_UMASK_LSB +: 8]),
				.events(ev_sib_q),
				.hit(hit_sib)
			);
			// Ring 0 is the OS bit; any other ring is the user bit.
			assign ok_self = (priv_self == 2'h0) ? sel_reg[g][`PEC_SEL_OS_BIT]
				: sel_reg[g][`PEC_SEL_USR_BIT];
			assign ok_sib = (priv_sibling == 2'h0) ? sel_reg[g][`PEC_SEL_OS_BIT]
				: sel_reg[g][`PEC_SEL_USR_BIT];
			// Both threads may hit in one cycle under any-thread, so one step can be two.
			assign gp_inc[g] = (gen_gp_reg[g] && sel_reg[g][`PEC_SEL_EN_BIT])
				? {1'b0, hit_self && ok_self}
				+ {1'b0, sel_reg[g][`PEC_SEL_ANY_BIT] && hit_sib && ok_sib} : 2'h0;
			// The carry out of the top bit is the wrap.
			assign gp_sum[g] = {1'b0, gp_reg[g]} + {{(W-1){1'b0}}, gp_inc[g]};
		end
	endgenerate

	// Fixed counters: 0 instructions, 1 core cycles, 2 reference cycles.
	logic [NF-1:0] fix_ev_self;
	logic [NF-1:0] fix_ev_sib;
	assign fix_ev_self = {ev_self_q.ref_cycle, ev_self_q.core_cycle, ev_self_q.inst_retired};
	assign fix_ev_sib = {ev_sib_q.ref_cycle, ev_sib_q.core_cycle, ev_sib_q.inst_retired};

	genvar f;
	generate
		for (f = 0; f < NF; f++) begin : fix_lane
			logic [3:0] blk;
			logic ok_self;
			logic ok_sib;
			assign blk = fctl_reg[f*`PEC_FIX_BLOCK +: `PEC_FIX_BLOCK];
			assign ok_self = (priv_self == 2'h0) ? blk[`PEC_FIX_OS_BIT]
				: blk[`PEC_FIX_USR_BIT];
			assign ok_sib = (priv_sibling == 2'h0) ? blk[`PEC_FIX_OS_BIT]
				: blk[`PEC_FIX_USR_BIT];
			assign fix_inc[f] = gen_fix_reg[f] ? {1'b0, fix_ev_self[f] && ok_self}
				+ {1'b0, blk[`PEC_FIX_ANY_BIT] && fix_ev_sib[f] && ok_sib} : 2'h0;
			assign fix_sum[f] = {1'b0, fix_reg[f]} + {{(W-1){1'b0}}, fix_inc[f]};
		end
	endgenerate

	// Address decode helpers.
	logic [11:0] a;
	assign a = req.addr;

	function automatic logic [W-1:0] sext32(input logic [31:0] v);
		sext32 = {{(W-32){v[31]}}, v};
	endfunction

	always_comb begin
		for (int i = 0; i < NG; i++) begin
			gp_next[i] = gp_sum[i][W-1:0];
			sel_next[i] = sel_reg[i];
		end
		for (int i = 0; i < NF; i++) begin
			fix_next[i] = fix_sum[i][W-1:0];
		end
		fctl_next = fctl_reg;
		gen_gp_next = gen_gp_reg;
		gen_fix_next = gen_fix_reg;
		ovf_gp_next = ovf_gp_reg;
		ovf_fix_next = ovf_fix_reg;
		rd_data_next = 64'h0;
		rd_valid_next = req.rd;
		// Software clear comes first so a same-cycle wrap still sets the flag.
		if (req.wr && a == `PEC_ADDR_GLB_OVF_CLR) begin
			ovf_gp_next = ovf_gp_reg & ~req.data[NG-1:0];
			ovf_fix_next = ovf_fix_reg & ~req.data[`PEC_GLB_FIX_LSB +: NF];
		end
		if (req.wr) begin
			for (int i = 0; i < NG; i++) begin
				if (a == `PEC_ADDR_GP_CTR + 12'(i))
					gp_next[i] = sext32(req.data[31:0]);
				if (a == `PEC_ADDR_ALIAS + 12'(i))
					gp_next[i] = req.data[W-1:0];
				if (a == `PEC_ADDR_EVTSEL + 12'(i))
					sel_next[i] = req.data;
			end
			for (int i = 0; i < NF; i++) begin
				if (a == `PEC_ADDR_FIX_CTR + 12'(i))
					fix_next[i] = req.data[W-1:0];
			end
			if (a == `PEC_ADDR_FIX_CTRL)
				fctl_next = req.data[4*NF-1:0];
			if (a == `PEC_ADDR_GLB_ENABLE) begin
				gen_gp_next = req.data[NG-1:0];
				gen_fix_next = req.data[`PEC_GLB_FIX_LSB +: NF];
			end
		end
		// Wrap past the top of the counter raises overflow in the same cycle.
		for (int i = 0; i < NG; i++) begin
			if (gp_sum[i][W]) begin
				ovf_gp_next[i] = 1'b1;
			end
		end
		for (int i = 0; i < NF; i++) begin
			if (fix_sum[i][W]) begin
				ovf_fix_next[i] = 1'b1;
			end
		end
		// Reads are side-effect free; general counter values sign-extend to 64 bits, fixed counter values zero-extend.
		if (req.rd) begin
			for (int i = 0; i < NG; i++) begin
				if (a == `PEC_ADDR_GP_CTR + 12'(i) || a == `PEC_ADDR_ALIAS + 12'(i))
					rd_data_next = {{(64-W){gp_reg[i][W-1]}}, gp_reg[i]};
				if (a == `PEC_ADDR_EVTSEL + 12'(i))
					rd_data_next = sel_reg[i];
			end
			for (int i = 0; i < NF; i++) begin
				if (a == `PEC_ADDR_FIX_CTR + 12'(i))
					rd_data_next = {{(64-W){1'b0}}, fix_reg[i]};
			end
			case (a)
				`PEC_ADDR_FIX_CTRL: rd_data_next = {{(64-4*NF){1'b0}}, fctl_reg};
				`PEC_ADDR_GLB_ENABLE: begin
					rd_data_next[NG-1:0] = gen_gp_reg;
					rd_data_next[`PEC_GLB_FIX_LSB +: NF] = gen_fix_reg;
				end
				`PEC_ADDR_GLB_STATUS: begin
					rd_data_next[NG-1:0] = ovf_gp_reg;
					rd_data_next[`PEC_GLB_FIX_LSB +: NF] = ovf_fix_reg;
				end
				`PEC_ADDR_CAPS: rd_data_next[`PEC_FULL_WIDTH_WRITE_CAPABLE_BIT] = 1'b1;
				default: rd_data_next = rd_data_next;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NG; i++) begin
				gp_reg[i] <= '0;
				sel_reg[i] <= 64'h0;
			end
			for (int i = 0; i < NF; i++) begin
				fix_reg[i] <= '0;
			end
			fctl_reg <= '0;
			gen_gp_reg <= '0;
			gen_fix_reg <= '0;
			ovf_gp_reg <= '0;
			ovf_fix_reg <= '0;
			rd_data_reg <= 64'h0;
			rd_valid_reg <= 1'b0;
		end else begin
			for (int i = 0; i < NG; i++) begin
				gp_reg[i] <= gp_next[i];
				sel_reg[i] <= sel_next[i];
			end
			for (int i = 0; i < NF; i++) begin
				fix_reg[i] <= fix_next[i];
			end
			fctl_reg <= fctl_next;
			gen_gp_reg <= gen_gp_next;
			gen_fix_reg <= gen_fix_next;
			ovf_gp_reg <= ovf_gp_next;
			ovf_fix_reg <= ovf_fix_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;

	// Enumeration words are constants of this build.
	always_comb begin
		enum_counters = 32'h0;
		enum_counters[`PEC_GP_COUNT_LSB +: 8] = 8'(NG);
		enum_counters[`PEC_GP_WIDTH_LSB +: 8] = 8'(W);
		enum_unavailable = {25'h0, `PEC_EVT_UNAVAIL_RESET};
	end
endmodule

// ==== verification/pec_unit_props.sv ====
/*
 * Port-level checks of the event counter unit.
 * Assumes it is bound to pec_unit and pec_params.svh is on the include path.
 */
`include "pec_params.svh"

module pec_unit_props (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register access
	input wire pec_pkg::pec_req_t req,
	input wire logic [63:0] rd_data,
	input wire logic rd_valid,
	// Enumeration
	input wire logic [31:0] enum_counters,
	input wire logic [31:0] enum_unavailable
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_read_answer: assert property (req.rd |=> rd_valid)
		else $error("read not answered");
	chk_no_spurious: assert property (!req.rd |=> !rd_valid && rd_data == 64'h0)
		else $error("answer without read");
	chk_gp_count: assert property (enum_counters[15:8] == 8'(`PEC_NUM_GP))
		else $error("counter count field wrong");
	chk_gp_width: assert property (enum_counters[23:16] == 8'(`PEC_CTR_WIDTH))
		else $error("counter width field wrong");
	chk_all_avail: assert property (enum_unavailable[6:0] == 7'h00)
		else $error("event marked unavailable");
	chk_fw_cap: assert property (req.rd && req.addr == `PEC_ADDR_CAPS |=> rd_data[13])
		else $error("full-width capability not advertised");
	chk_enable_bits: assert property (req.rd && req.addr == `PEC_ADDR_GLB_ENABLE
		|=> rd_data[31:2] == 30'h0 && rd_data[63:35] == 29'h0)
		else $error("enable holds bits of absent counters");
	chk_status_bits: assert property (req.rd && req.addr == `PEC_ADDR_GLB_STATUS
		|=> rd_data[31:2] == 30'h0 && rd_data[63:35] == 29'h0)
		else $error("status holds bits of absent counters");
	chk_unmapped_read: assert property (req.rd && req.addr == 12'h000 |=> rd_data == 64'h0)
		else $error("unmapped read not zero");
	chk_sign_ext: assert property (req.rd && req.addr[11:2] == 10'h030
		|=> rd_data[63:48] == {16{rd_data[47]}})
		else $error("counter read not sign-extended");
endmodule

bind pec_unit pec_unit_props u_pec_unit_props (.clk(clk), .sys_rst(sys_rst), .req(req),
	.rd_data(rd_data), .rd_valid(rd_valid), .enum_counters(enum_counters),
	.enum_unavailable(enum_unavailable));

// ==== verification/pec_event_source.sv ====
/*
 * Event source standing for the core pipeline, caches and sibling thread.
 * Assumes the bench calls fire just after a rising edge of clk.
 */
module pec_event_source (
	// Clock
	input wire logic clk,
	// Event pulses
	output pec_pkg::pec_events_t events_self,
	output pec_pkg::pec_events_t events_sibling,
	output logic ref_clock_tick
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		events_self = '0;
		events_sibling = '0;
		ref_clock_tick = 1'b0;
	end

	// The reference tick is shared by both threads, so it stands in for their ref bits.
	task automatic fire(input pec_pkg::pec_events_t s, input pec_pkg::pec_events_t b, input int n);
		for (int i = 0; i <= n; i++) begin
			@(posedge clk);
			#1;
			events_self = (i < n) ? s : '0;
			events_sibling = (i < n) ? b : '0;
			ref_clock_tick = (i < n) && (s.ref_cycle || b.ref_cycle);
		end
	endtask
endmodule

// ==== verification/pec_unit_test.sv ====
/*
 * Self-checking bench of the event counter unit.
 * Assumes the package, the unit, its checker and the event source are compiled first.
 */
`include "pec_params.svh"

module pec_unit_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	pec_pkg::pec_req_t req = '0;
	logic [63:0] rd_data;
	logic rd_valid;
	logic [31:0] enum_counters;
	logic [31:0] enum_unavailable;
	pec_pkg::pec_events_t events_self;
	pec_pkg::pec_events_t events_sibling;
	logic [1:0] priv_self = 2'h0;
	logic [1:0] priv_sibling = 2'h0;
	pec_pkg::pec_core_state_t core_state = '0;
	logic ref_clock_tick;
	logic [63:0] got;
	int fail_count = 0;
	int tests_run = 0;
	localparam logic [63:0] SEL_ON = 64'h0000_0000_0043_0000;

	always #10 clk = ~clk;

	pec_unit u_pec_unit (.clk(clk), .sys_rst(sys_rst), .req(req), .rd_data(rd_data),
		.rd_valid(rd_valid), .enum_counters(enum_counters), .enum_unavailable(enum_unavailable),
		.events_self(events_self), .events_sibling(events_sibling), .priv_self(priv_self),
		.priv_sibling(priv_sibling), .core_state(core_state), .ref_clock_tick(ref_clock_tick));
	pec_event_source u_pec_event_source (.clk(clk), .events_self(events_self),
		.events_sibling(events_sibling), .ref_clock_tick(ref_clock_tick));

	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] seen);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] addr, input logic [63:0] data);
		@(posedge clk);
		#1;
		req.wr = 1'b1;
		req.addr = addr;
		req.data = data;
		@(posedge clk);
		#1;
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [11:0] addr);
		@(posedge clk);
		#1;
		req.rd = 1'b1;
		req.addr = addr;
		@(posedge clk);
		#1;
		req.rd = 1'b0;
		got = rd_data;
		check("rd_valid", 64'h1, {63'h0, rd_valid});
	endtask

	task automatic count(input logic [63:0] sel, input logic [6:0] s, input logic [6:0] b,
		input logic [63:0] exp, input string name);
		wr(`PEC_ADDR_EVTSEL, 64'h0);
		wr(`PEC_ADDR_GP_CTR, 64'h0);
		wr(`PEC_ADDR_EVTSEL, sel);
		u_pec_event_source.fire(s, b, 3);
		repeat (2) @(posedge clk);
		rd(`PEC_ADDR_GP_CTR);
		check(name, exp, got);
	endtask

	task automatic t_regs;
		check("gp count", 64'(`PEC_NUM_GP), {56'h0, enum_counters[15:8]});
		check("gp width", 64'(`PEC_CTR_WIDTH), {56'h0, enum_counters[23:16]});
		check("unavailable", 64'h0, {57'h0, enum_unavailable[6:0]});
		rd(`PEC_ADDR_CAPS);
		check("fw cap", 64'h1, {63'h0, got[13]});
		rd(12'h000);
		check("unmapped", 64'h0, got);
		rd(`PEC_ADDR_GLB_STATUS);
		check("status reset", 64'h0, got);
		wr(12'h0c1, 64'hffff_0000_8000_0001);
		wr(12'h0c2, 64'h5555_0000_1234_5678);
		rd(12'h0c1);
		check("gp0 normal", 64'hffff_ffff_8000_0001, got);
		rd(12'h0c2);
		check("gp1 normal", 64'h0000_0000_1234_5678, got);
		wr(12'h4c1, 64'h0000_7fff_0000_0005);
		wr(12'h4c2, 64'h0000_8000_0000_0009);
		rd(12'h0c1);
		check("gp0 alias", 64'h0000_7fff_0000_0005, got);
		rd(12'h0c2);
		check("gp1 alias", 64'hffff_8000_0000_0009, got);
	endtask

	task automatic t_events;
		logic [7:0] ev [0:6] = '{8'h3c, 8'h3c, 8'hc0, 8'h2e, 8'h2e, 8'hc4, 8'hc5};
		logic [7:0] um [0:6] = '{8'h00, 8'h01, 8'h00, 8'h4f, 8'h41, 8'h00, 8'h00};
		wr(`PEC_ADDR_GLB_ENABLE, 64'h0000_0007_0000_0003);
		for (int i = 0; i < 7; i++) begin
			count(SEL_ON | {48'h0, um[i], ev[i]}, 7'h40 >> i, 7'h0, 64'h3, "hit");
			count(SEL_ON | {48'h0, um[i], ev[i]}, ~(7'h40 >> i), 7'h0, 64'h0, "miss");
		end
	endtask

	task automatic t_gate;
		for (int i = 1; i < 6; i++) begin
			core_state = 6'h01 << i;
			count(SEL_ON | 64'h3c, 7'h40, 7'h0, 64'h0, "gated cycles");
		end
		core_state = 6'h01;
		count(SEL_ON | 64'hc0, 7'h10, 7'h10, 64'h0, "vm exit");
		core_state = '0;
		count(SEL_ON | 64'hc0, 7'h0, 7'h10, 64'h0, "own thread");
		count(SEL_ON | 64'h20_00c0, 7'h0, 7'h10, 64'h3, "any thread");
		count(SEL_ON | 64'h20_00c0, 7'h10, 7'h10, 64'h6, "both threads");
		priv_sibling = 2'h3;
		count(64'h0062_00c0, 7'h0, 7'h10, 64'h0, "sibling user");
		priv_sibling = 2'h0;
		priv_self = 2'h3;
		count(64'h0042_00c0, 7'h10, 7'h0, 64'h0, "os only at user");
		priv_self = 2'h0;
		wr(`PEC_ADDR_GLB_ENABLE, 64'h0);
		count(SEL_ON | 64'hc0, 7'h10, 7'h0, 64'h0, "global off");
	endtask

	task automatic t_fixed;
		wr(`PEC_ADDR_GLB_ENABLE, 64'h0000_0007_0000_0000);
		wr(`PEC_ADDR_FIX_CTRL, 64'h317);
		wr(12'h30a, 64'h0000_ffff_ffff_fffe);
		u_pec_event_source.fire(7'h50, 7'h10, 2);
		priv_self = 2'h3;
		u_pec_event_source.fire(7'h60, 7'h0, 2);
		priv_self = 2'h0;
		repeat (2) @(posedge clk);
		rd(12'h30a);
		check("fixed wrap", 64'h0, got);
		rd(12'h309);
		check("fixed any", 64'h4, got);
		rd(12'h30b);
		check("fixed ref", 64'h2, got);
		rd(`PEC_ADDR_GLB_STATUS);
		check("overflow", 64'h0000_0002_0000_0000, got);
		wr(`PEC_ADDR_GLB_OVF_CLR, 64'h0000_0002_0000_0000);
		rd(`PEC_ADDR_GLB_STATUS);
		check("cleared", 64'h0, got);
	endtask

	task automatic end_sim;
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_regs;
		t_events;
		t_gate;
		t_fixed;
		end_sim;
	end

	initial begin
		#100000;
		fail_count++;
		end_sim;
	end
endmodule
